// ---- rtl/data_space_pkg.sv ----
package data_space_pkg;

  // Address space geometry
  localparam int          EA_W          = 16;
  localparam int          DATA_W        = 16;
  localparam int          PAGE_W        = 9;
  localparam int          EXT_W         = 24;
  localparam int          NEAR_W        = 13;
  localparam int          NUM_WREGS     = 16;
  localparam int          RAM_BYTES_DEF = 49152;

  // Region boundaries
  localparam logic [15:0] SFR_LAST      = 16'h0FFF;
  localparam logic [15:0] NEAR_LAST     = 16'h1FFF;
  localparam logic [15:0] RAM_BASE      = 16'h1000;
  localparam logic [8:0]  PAGE_BASE     = 9'h001;

  // Core register offsets inside the SFR region
  localparam logic [15:0] WREG_BASE     = 16'h0000;
  localparam logic [15:0] WREG_LAST     = 16'h001E;
  localparam logic [15:0] RD_PAGE_OFS   = 16'h0032;
  localparam logic [15:0] WR_PAGE_OFS   = 16'h0034;
  localparam logic [15:0] LOOP_LO_OFS   = 16'h003A;
  localparam logic [15:0] LOOP_HI_OFS   = 16'h003C;

  // Values after reset
  localparam logic [15:0] WREG_RST      = 16'h0000;
  localparam logic [8:0]  PAGE_RST      = 9'h001;
  localparam logic [23:0] LOOP_RST      = 24'h00_0000;

  // Byte lane strobes
  localparam logic [1:0]  LANE_NONE     = 2'h0;
  localparam logic [1:0]  LANE_LOW      = 2'h1;
  localparam logic [1:0]  LANE_HIGH     = 2'h2;
  localparam logic [1:0]  LANE_BOTH     = 2'h3;

  typedef enum logic [1:0] {
    MODE_DIRECT   = 2'h0,
    MODE_NEAR     = 2'h1,
    MODE_INDIRECT = 2'h2,
    MODE_POSTINC  = 2'h3
  } addr_mode_t;

  typedef logic [NUM_WREGS-1:0][DATA_W-1:0] wreg_file_t;

  typedef struct packed {
    logic        valid;
    addr_mode_t  mode;
    logic        byte_op;
    logic [15:0] addr;
    logic [3:0]  ptr;
    logic [15:0] data;
  } access_t;

  typedef struct packed {
    logic       en;
    logic [3:0] dest;
  } load_t;

  typedef struct packed {
    logic       en;
    logic       sign;
    logic [3:0] sel;
  } ext_t;

  typedef struct packed {
    wreg_file_t  w;
    logic [8:0]  rd_page;
    logic [8:0]  wr_page;
    logic [23:0] loop_start;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic [23:0] rd_ext;
    logic [23:0] wr_ext;
    logic [1:0]  strobe;
    logic        trap;
    logic        trap_wr;
  } state_t;

endpackage : data_space_pkg

// ---- rtl/data_space_access_unit.sv ----
`timescale 1ns/10ps
`default_nettype none

// Function
// - Effective addresses are 16 bits and each value names one byte.
// - The base data space is 64 Kbytes, that is 32K words.
// - Read and write pages extend the base address to a 16-Mbyte space.
// - 4 Kbytes of SFRs, up to 48 Kbytes RAM; elsewhere reads give zero.
// - Low byte sits at the even address, high byte at the odd one.
// - Post-increment adds one for byte and two for word operations.
// - Byte read fetches the word, address bit 0 picks the byte onto low byte.
// - Shared word decode, separate lane strobes; byte write touches one lane only.
// - Word access at an odd address raises an address error trap.
// - Misaligned read completes, misaligned write is suppressed, then trap.
// - Byte loads into a working register change only its low byte.
// - Sign-extend turns 8-bit signed into 16-bit; zero-extend clears the high byte.
// - Addresses 0x0000 to 0x0FFF decode to the special function registers.
// - Unoccupied SFR addresses read as zero.
// - The 8-Kbyte near region is reached through a 13-bit direct field.
// - The whole space is reached by a 16-bit direct field or a pointer register.
// - Separate read and write address generators serve data accesses.
// - Core registers, working and page registers included, are memory mapped.
// - Loop start high and low halves are read-only to software.
module data_space_access_unit #(
  parameter int RAM_BYTES = data_space_pkg::RAM_BYTES_DEF
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // Read address generator and load path
  input  wire data_space_pkg::access_t    rd_acc,
  input  wire data_space_pkg::load_t      rd_load,
  output logic [15:0]                     rd_data,
  output logic                            rd_valid,
  output logic [23:0]                     rd_ext_addr,
  // Write address generator
  input  wire data_space_pkg::access_t    wr_acc,
  output logic [1:0]                      wr_lane_strobe,
  output logic [23:0]                     wr_ext_addr,
  // Extend operations
  input  wire data_space_pkg::ext_t       ext_op,
  // Loop start capture from the sequencer
  input  wire logic                       loop_start_load,
  input  wire logic [23:0]                loop_start_value,
  // Trap and register view
  output logic                            addr_err_trap,
  output logic                            addr_err_on_write,
  output data_space_pkg::wreg_file_t      wreg_file
);
  import data_space_pkg::*;

  localparam int          RAM_WORDS = RAM_BYTES / 2;
  localparam int          RAM_AW    = $clog2(RAM_WORDS);
  localparam logic [16:0] RAM_END   = 17'(RAM_BASE) + 17'(RAM_BYTES);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [15:0] ea_calc(input access_t acc, input wreg_file_t w);
    logic [15:0] ea;
    ea = 16'h0000;
    unique case (acc.mode)
      MODE_DIRECT:   ea = acc.addr;
      MODE_NEAR:     ea = {3'h0, acc.addr[NEAR_W-1:0]};
      MODE_INDIRECT: ea = w[acc.ptr];
      MODE_POSTINC:  ea = w[acc.ptr];
    endcase
    return ea;
  endfunction : ea_calc

  // Upper half of the base space lands in RAM only through the base page
  function automatic logic ram_hit(input logic [15:0] ea, input logic [8:0] page);
    return (ea >= RAM_BASE) && ({1'b0, ea} < RAM_END)
           && (!ea[15] || page == PAGE_BASE);
  endfunction : ram_hit

  function automatic logic [RAM_AW-1:0] ram_index(input logic [15:0] ea);
    logic [15:0] ofs;
    ofs = ea - RAM_BASE;
    return ofs[RAM_AW:1];
  endfunction : ram_index

  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] nw,
                                             input logic [1:0] strobe);
    return {strobe[1] ? nw[15:8] : old[15:8], strobe[0] ? nw[7:0] : old[7:0]};
  endfunction : lane_merge

  function automatic logic [15:0] step(input logic byte_op);
    return byte_op ? 16'h0001 : 16'h0002;
  endfunction : step

  // Extended address: upper half of the base space is windowed by the page
  function automatic logic [23:0] ext_addr(input logic [15:0] ea, input logic [8:0] page);
    return ea[15] ? {page, ea[14:0]} : {8'h00, ea};
  endfunction : ext_addr

  function automatic logic [15:0] sfr_read(input logic [15:0] a, input state_t st);
    logic [15:0] v;
    v = 16'h0000;
    if (a <= WREG_LAST) begin
      v = st.w[a[4:1]];
    end else if (a == RD_PAGE_OFS) begin
      v = {7'h00, st.rd_page};
    end else if (a == WR_PAGE_OFS) begin
      v = {7'h00, st.wr_page};
    end else if (a == LOOP_LO_OFS) begin
      v = st.loop_start[15:0];
    end else if (a == LOOP_HI_OFS) begin
      v = {8'h00, st.loop_start[23:16]};
    end
    return v;
  endfunction : sfr_read

  ////////////////////////////////////////////////////////////////////////////
  // State and memory

  state_t      s_reg;
  state_t      s_next;
  logic [15:0] ram [RAM_WORDS];

  logic [15:0] rd_ea;
  logic [15:0] wr_ea;
  logic [15:0] rd_word_addr;
  logic [15:0] rd_word;
  logic [7:0]  rd_byte;
  logic [15:0] rd_result;
  logic        rd_mis;
  logic        wr_mis;
  logic [1:0]  wr_strobe;
  logic [15:0] wr_lanes;
  logic        wr_ram;
  logic [15:0] wr_word_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Address generation and read path

  always_comb begin
    rd_ea        = ea_calc(rd_acc, s_reg.w);
    wr_ea        = ea_calc(wr_acc, s_reg.w);
    rd_mis       = rd_acc.valid && !rd_acc.byte_op && rd_ea[0];
    wr_mis       = wr_acc.valid && !wr_acc.byte_op && wr_ea[0];
    rd_word_addr = {rd_ea[15:1], 1'b0};
    wr_word_addr = {wr_ea[15:1], 1'b0};
    // One word decode serves both lanes; a byte read still fetches the word
    if (rd_word_addr <= SFR_LAST) begin
      rd_word = sfr_read(rd_word_addr, s_reg);
    end else if (ram_hit(rd_word_addr, s_reg.rd_page)) begin
      rd_word = ram[ram_index(rd_word_addr)];
    end else begin
      rd_word = 16'h0000;
    end
    rd_byte   = rd_ea[0] ? rd_word[15:8] : rd_word[7:0];
    rd_result = rd_acc.byte_op ? {8'h00, rd_byte} : rd_word;
    // Write strobes; a misaligned word write is executed without storing
    if (!wr_acc.valid || wr_mis) begin
      wr_strobe = LANE_NONE;
    end else if (wr_acc.byte_op) begin
      wr_strobe = wr_ea[0] ? LANE_HIGH : LANE_LOW;
    end else begin
      wr_strobe = LANE_BOTH;
    end
    wr_lanes = wr_acc.byte_op ? {wr_acc.data[7:0], wr_acc.data[7:0]} : wr_acc.data;
    wr_ram   = ram_hit(wr_word_addr, s_reg.wr_page) && (wr_strobe != LANE_NONE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state; later updates of a working register win over earlier ones

  always_comb begin
    s_next = s_reg;
    // Pointer updates go first so an explicit store or load can override
    if (rd_acc.valid && rd_acc.mode == MODE_POSTINC) begin
      s_next.w[rd_acc.ptr] = s_next.w[rd_acc.ptr] + step(rd_acc.byte_op);
    end
    if (wr_acc.valid && wr_acc.mode == MODE_POSTINC) begin
      s_next.w[wr_acc.ptr] = s_next.w[wr_acc.ptr] + step(wr_acc.byte_op);
    end
    if (ext_op.en) begin
      s_next.w[ext_op.sel] = ext_op.sign ? {{8{s_reg.w[ext_op.sel][7]}}, s_reg.w[ext_op.sel][7:0]}
                                         : {8'h00, s_reg.w[ext_op.sel][7:0]};
    end
    // A misaligned read still completes, including its load
    if (rd_acc.valid && rd_load.en) begin
      s_next.w[rd_load.dest] = lane_merge(s_next.w[rd_load.dest], rd_result,
                                          rd_acc.byte_op ? LANE_LOW : LANE_BOTH);
    end
    if (wr_strobe != LANE_NONE && wr_word_addr <= WREG_LAST) begin
      s_next.w[wr_word_addr[4:1]] = lane_merge(s_next.w[wr_word_addr[4:1]], wr_lanes, wr_strobe);
    end
    if (wr_strobe != LANE_NONE && wr_word_addr == RD_PAGE_OFS) begin
      s_next.rd_page = 9'(lane_merge({7'h00, s_reg.rd_page}, wr_lanes, wr_strobe));
    end
    if (wr_strobe != LANE_NONE && wr_word_addr == WR_PAGE_OFS) begin
      s_next.wr_page = 9'(lane_merge({7'h00, s_reg.wr_page}, wr_lanes, wr_strobe));
    end
    // Stores to the loop start words are dropped; only the sequencer loads it
    if (loop_start_load) begin
      s_next.loop_start = loop_start_value;
    end
    s_next.rd_valid = rd_acc.valid;
    if (rd_acc.valid) begin
      s_next.rd_data = rd_result;
      s_next.rd_ext  = ext_addr(rd_ea, s_reg.rd_page);
    end
    if (wr_acc.valid) begin
      s_next.wr_ext = ext_addr(wr_ea, s_reg.wr_page);
    end
    s_next.strobe  = wr_strobe;
    s_next.trap    = rd_mis || wr_mis;
    s_next.trap_wr = wr_mis;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg            <= '0;
      s_reg.w          <= {NUM_WREGS{WREG_RST}};
      s_reg.rd_page    <= PAGE_RST;
      s_reg.wr_page    <= PAGE_RST;
      s_reg.loop_start <= LOOP_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // RAM has no reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (wr_ram) begin
      ram[ram_index(wr_word_addr)] <= lane_merge(ram[ram_index(wr_word_addr)], wr_lanes, wr_strobe);
    end
  end

  assign rd_data           = s_reg.rd_data;
  assign rd_valid          = s_reg.rd_valid;
  assign rd_ext_addr       = s_reg.rd_ext;
  assign wr_ext_addr       = s_reg.wr_ext;
  assign wr_lane_strobe    = s_reg.strobe;
  assign addr_err_trap     = s_reg.trap;
  assign addr_err_on_write = s_reg.trap_wr;
  assign wreg_file         = s_reg.w;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Expected value of one working register after a single isolated operation
  logic        exp_arm;
  logic [1:0]  exp_kind;
  logic [3:0]  exp_idx;
  logic [15:0] exp_val;
  logic        only_rd;

  assign only_rd = rd_acc.valid && !wr_acc.valid && !ext_op.en;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exp_arm  <= 1'b0;
      exp_kind <= 2'h0;
      exp_idx  <= 4'h0;
      exp_val  <= 16'h0000;
    end else begin
      exp_arm <= 1'b1;
      if (only_rd && rd_acc.mode == MODE_POSTINC && !rd_load.en) begin
        exp_kind <= 2'h1;
        exp_idx  <= rd_acc.ptr;
        exp_val  <= s_reg.w[rd_acc.ptr] + step(rd_acc.byte_op);
      end else if (only_rd && rd_acc.mode != MODE_POSTINC && rd_load.en && rd_acc.byte_op) begin
        exp_kind <= 2'h2;
        exp_idx  <= rd_load.dest;
        exp_val  <= s_reg.w[rd_load.dest];
      end else if (ext_op.en && !rd_acc.valid && !wr_acc.valid) begin
        exp_kind <= 2'h3;
        exp_idx  <= ext_op.sel;
        exp_val  <= ext_op.sign ? {{8{s_reg.w[ext_op.sel][7]}}, s_reg.w[ext_op.sel][7:0]}
                                : {8'h00, s_reg.w[ext_op.sel][7:0]};
      end else begin
        exp_kind <= 2'h0;
      end
    end
  end

  sequence s_read_mis;
    rd_mis && !wr_mis;
  endsequence

  sequence s_read_trap;
    addr_err_trap && !addr_err_on_write;
  endsequence

  sequence s_write_trap;
    addr_err_trap && addr_err_on_write && wr_lane_strobe == LANE_NONE;
  endsequence

  chk_read_trap_raised: assert property (s_read_mis |=> s_read_trap)
    else $error("misaligned read gave no trap");

  chk_write_trap_suppress: assert property (wr_mis |-> wr_strobe == LANE_NONE ##1 s_write_trap)
    else $error("misaligned write stored or gave no trap");

  chk_word_both_lanes: assert property (wr_acc.valid && !wr_acc.byte_op && !wr_ea[0] |=> wr_lane_strobe == LANE_BOTH)
    else $error("aligned word write missed a lane");

  chk_byte_one_lane: assert property (wr_acc.valid && wr_acc.byte_op
                                      |=> $onehot(wr_lane_strobe) && wr_lane_strobe[1] == $past(wr_ea[0]))
    else $error("byte write strobe wrong");

  chk_byte_read_low: assert property (rd_acc.valid && rd_acc.byte_op |=> rd_valid && rd_data[15:8] == 8'h00)
    else $error("byte read not on low byte");

  chk_unimpl_read_zero: assert property (rd_acc.valid && rd_word_addr > SFR_LAST && !ram_hit(rd_word_addr, s_reg.rd_page)
                                         |=> rd_data == 16'h0000)
    else $error("unimplemented address read nonzero");

  chk_sfr_hole_zero: assert property (rd_acc.valid && !rd_acc.byte_op && rd_word_addr > LOOP_HI_OFS && rd_word_addr <= SFR_LAST
                                      |=> rd_data == 16'h0000)
    else $error("empty SFR address read nonzero");

  chk_loop_start_ro: assert property (!loop_start_load |=> s_reg.loop_start == $past(s_reg.loop_start))
    else $error("loop start changed without sequencer load");

  chk_postinc_step: assert property (exp_arm && exp_kind == 2'h1 |-> wreg_file[exp_idx] == exp_val)
    else $error("pointer post-increment wrong");

  chk_byte_load_high: assert property (exp_arm && exp_kind == 2'h2 |-> wreg_file[exp_idx][15:8] == exp_val[15:8])
    else $error("byte load changed high byte");

  chk_extend_result: assert property (exp_arm && exp_kind == 2'h3 |-> wreg_file[exp_idx] == exp_val)
    else $error("extend result wrong");

  chk_read_valid_follow: assert property (1'b1 |=> rd_valid == $past(rd_acc.valid))
    else $error("read valid does not follow request");

  chk_trap_only_mis: assert property (!rd_mis && !wr_mis |=> !addr_err_trap)
    else $error("trap without misaligned access");

  chk_near_window: assert property (rd_acc.valid && rd_acc.mode == MODE_NEAR |=> rd_ext_addr[23:13] == 11'h000)
    else $error("near read left the near region");

  chk_idle_no_strobe: assert property (!wr_acc.valid |=> wr_lane_strobe == LANE_NONE)
    else $error("strobe without write request");

endmodule : data_space_access_unit

`default_nettype wire

// ---- bench/core_agu_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module core_agu_model (
  // Clock
  input  wire logic                     clk,
  // Requests toward the data space
  output var data_space_pkg::access_t   rd_acc,
  output var data_space_pkg::load_t     rd_load,
  output var data_space_pkg::access_t   wr_acc
);
  import data_space_pkg::*;

  initial begin
    rd_acc  = '0;
    rd_load = '0;
    wr_acc  = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One request per call, launched after a falling edge and held one full cycle
  // Word requests normally carry even addresses; odd ones come only when asked
  task automatic issue(input access_t r, input access_t w, input load_t l);
    @(negedge clk);
    rd_acc  = r;
    wr_acc  = w;
    rd_load = l;
    @(negedge clk);
    // Released fields show the inverse, so a stale value never passes for data
    rd_acc  = {1'h0, ~r[38:0]};
    wr_acc  = {1'h0, ~w[38:0]};
    rd_load = {1'h0, ~l[3:0]};
  endtask : issue

endmodule : core_agu_model

`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import data_space_pkg::*;

  typedef struct packed {
    logic        wr;
    addr_mode_t  mode;
    logic        bop;
    logic [15:0] addr;
    logic [3:0]  ptr;
    logic [15:0] data;
    logic [15:0] exp;
    logic        trap;
    logic [23:0] ext;
  } row_t;

  localparam addr_mode_t DIR    = MODE_DIRECT;
  localparam access_t    IDLE   = '0;
  localparam load_t      NOLOAD = '0;
  localparam int         NROW   = 23;

  // Writes expect lane strobes in exp, reads expect data
  localparam row_t ROWS [NROW] = '{
    '{1'h1, DIR, 1'h0, 16'h1000, 4'h0, 16'h1234, 16'h0003, 1'h0, 24'h00_1000},
    '{1'h0, DIR, 1'h0, 16'h1000, 4'h0, 16'h0000, 16'h1234, 1'h0, 24'h00_1000},
    '{1'h1, DIR, 1'h1, 16'h1001, 4'h0, 16'h00AB, 16'h0002, 1'h0, 24'h00_1001},
    '{1'h0, DIR, 1'h0, 16'h1000, 4'h0, 16'h0000, 16'hAB34, 1'h0, 24'h00_1000},
    '{1'h0, DIR, 1'h1, 16'h1001, 4'h0, 16'h0000, 16'h00AB, 1'h0, 24'h00_1001},
    '{1'h0, DIR, 1'h1, 16'h1000, 4'h0, 16'h0000, 16'h0034, 1'h0, 24'h00_1000},
    '{1'h1, DIR, 1'h1, 16'h1000, 4'h0, 16'h0056, 16'h0001, 1'h0, 24'h00_1000},
    '{1'h0, DIR, 1'h0, 16'h1000, 4'h0, 16'h0000, 16'hAB56, 1'h0, 24'h00_1000},
    '{1'h1, DIR, 1'h0, 16'h1002, 4'h0, 16'h5555, 16'h0003, 1'h0, 24'h00_1002},
    '{1'h1, DIR, 1'h0, 16'h1003, 4'h0, 16'hFFFF, 16'h0000, 1'h1, 24'h00_1003},
    '{1'h0, DIR, 1'h0, 16'h1002, 4'h0, 16'h0000, 16'h5555, 1'h0, 24'h00_1002},
    '{1'h0, DIR, 1'h0, 16'h1001, 4'h0, 16'h0000, 16'hAB56, 1'h1, 24'h00_1001},
    '{1'h0, DIR, 1'h0, 16'h0100, 4'h0, 16'h0000, 16'h0000, 1'h0, 24'h00_0100},
    '{1'h0, DIR, 1'h0, 16'h2000, 4'h0, 16'h0000, 16'h0000, 1'h0, 24'h00_2000},
    '{1'h0, MODE_NEAR, 1'h0, 16'hF000, 4'h0, 16'h0000, 16'hAB56, 1'h0, 24'h00_1000},
    '{1'h0, DIR, 1'h0, 16'h0032, 4'h0, 16'h0000, 16'h0001, 1'h0, 24'h00_0032},
    '{1'h1, DIR, 1'h0, 16'h0006, 4'h0, 16'h1002, 16'h0003, 1'h0, 24'h00_0006},
    '{1'h0, MODE_INDIRECT, 1'h0, 16'h0000, 4'h3, 16'h0000, 16'h5555, 1'h0, 24'h00_1002},
    '{1'h1, DIR, 1'h0, 16'h000A, 4'h0, 16'h7700, 16'h0003, 1'h0, 24'h00_000A},
    '{1'h0, DIR, 1'h0, 16'h0006, 4'h0, 16'h0000, 16'h1002, 1'h0, 24'h00_0006},
    '{1'h1, DIR, 1'h0, 16'h0032, 4'h0, 16'h0003, 16'h0003, 1'h0, 24'h00_0032},
    '{1'h1, DIR, 1'h0, 16'h0034, 4'h0, 16'h0005, 16'h0003, 1'h0, 24'h00_0034},
    '{1'h0, DIR, 1'h0, 16'h0034, 4'h0, 16'h0000, 16'h0005, 1'h0, 24'h00_0034}
  };

  logic        clk;
  logic        rst;
  access_t     rd_acc;
  load_t       rd_load;
  access_t     wr_acc;
  ext_t        ext_op;
  logic        loop_start_load;
  logic [23:0] loop_start_value;
  logic [15:0] rd_data;
  logic        rd_valid;
  logic [23:0] rd_ext_addr;
  logic [1:0]  wr_lane_strobe;
  logic [23:0] wr_ext_addr;
  logic        addr_err_trap;
  logic        addr_err_on_write;
  wreg_file_t  wreg_file;
  int          fails;
  int          compares;
  row_t        r;
  access_t     a;

  ////////////////////////////////////////////////////////////////////////////////
  // Small RAM keeps the unimplemented area easy to reach
  data_space_access_unit #(.RAM_BYTES(256)) u_data_space_access_unit (
    .clk(clk), .rst(rst), .rd_acc(rd_acc), .rd_load(rd_load), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_ext_addr(rd_ext_addr), .wr_acc(wr_acc),
    .wr_lane_strobe(wr_lane_strobe), .wr_ext_addr(wr_ext_addr), .ext_op(ext_op),
    .loop_start_load(loop_start_load), .loop_start_value(loop_start_value),
    .addr_err_trap(addr_err_trap), .addr_err_on_write(addr_err_on_write), .wreg_file(wreg_file)
  );

  core_agu_model u_core_agu_model (
    .clk(clk), .rd_acc(rd_acc), .rd_load(rd_load), .wr_acc(wr_acc)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rd1(input addr_mode_t m, input logic b, input logic [15:0] ad, input logic [3:0] p,
                     input load_t l);
    u_core_agu_model.issue('{1'h1, m, b, ad, p, 16'h0000}, IDLE, l);
  endtask : rd1

  task automatic stop_test;
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // Whole run is about 75 cycles; this leaves ample slack
  initial begin
    #(2000 * 50);
    fails++;
    stop_test();
  end

  initial begin
    fails = 0;
    compares = 0;
    rst = 1'h1;
    ext_op = '0;
    loop_start_load = 1'h0;
    loop_start_value = 24'h00_0000;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    for (int i = 0; i < NROW; i++) begin
      r = ROWS[i];
      a = '{1'h1, r.mode, r.bop, r.addr, r.ptr, r.data};
      if (r.wr) begin
        u_core_agu_model.issue(IDLE, a, NOLOAD);
        chk({22'h0, wr_lane_strobe}, {22'h0, r.exp[1:0]});
        chk(wr_ext_addr, r.ext);
      end else begin
        u_core_agu_model.issue(a, IDLE, NOLOAD);
        chk({7'h0, rd_valid, rd_data}, {7'h0, 1'h1, r.exp});
        chk(rd_ext_addr, r.ext);
      end
      chk({22'h0, addr_err_trap, addr_err_on_write}, {22'h0, r.trap, r.trap & r.wr});
    end
    // Post-increment by byte, then by word from an odd pointer
    rd1(MODE_POSTINC, 1'h1, 16'h0000, 4'h3, NOLOAD);
    @(negedge clk);
    chk({23'h0, rd_valid}, 24'h00_0000);
    chk({8'h00, wreg_file[3]}, 24'h00_1003);
    rd1(MODE_POSTINC, 1'h0, 16'h0000, 4'h3, NOLOAD);
    chk({23'h0, addr_err_trap}, 24'h00_0001);
    @(negedge clk);
    chk({8'h00, wreg_file[3]}, 24'h00_1005);
    // Byte load keeps the high byte, then both extensions
    rd1(DIR, 1'h1, 16'h1001, 4'h0, '{1'h1, 4'h5});
    @(negedge clk);
    chk({8'h00, wreg_file[5]}, 24'h00_77AB);
    ext_op = '{1'h1, 1'h1, 4'h5};
    @(negedge clk);
    ext_op = '{1'h1, 1'h0, 4'h5};
    chk({8'h00, wreg_file[5]}, 24'h00_FFAB);
    @(negedge clk);
    ext_op = '0;
    chk({8'h00, wreg_file[5]}, 24'h00_00AB);
    // Loop start loads from the sequencer but ignores software writes
    loop_start_load = 1'h1;
    loop_start_value = 24'h12_3456;
    @(negedge clk);
    loop_start_load = 1'h0;
    u_core_agu_model.issue(IDLE, '{1'h1, DIR, 1'h0, 16'h003A, 4'h0, 16'hBEEF}, NOLOAD);
    rd1(DIR, 1'h0, 16'h003A, 4'h0, NOLOAD);
    chk({8'h00, rd_data}, 24'h00_3456);
    rd1(DIR, 1'h0, 16'h003C, 4'h0, NOLOAD);
    chk({8'h00, rd_data}, 24'h00_0012);
    // Read and write together, each through its own page
    u_core_agu_model.issue('{1'h1, DIR, 1'h0, 16'h8002, 4'h0, 16'h0000},
                           '{1'h1, DIR, 1'h0, 16'h8004, 4'h0, 16'h1111}, NOLOAD);
    chk(rd_ext_addr, 24'h01_8002);
    chk(wr_ext_addr, 24'h02_8004);
    chk({8'h00, rd_data}, 24'h00_0000);
    // Reset in mid-run brings mapped registers back
    rst = 1'h1;
    @(negedge clk);
    rst = 1'h0;
    rd1(DIR, 1'h0, 16'h000A, 4'h0, NOLOAD);
    chk({8'h00, rd_data}, 24'h00_0000);
    rd1(DIR, 1'h0, 16'h0034, 4'h0, NOLOAD);
    chk({8'h00, rd_data}, 24'h00_0001);
    stop_test();
  end

endmodule : testbench

`default_nettype wire
